// >>> dual_clock_fifo_flags.sv
// Dual-clock FIFO with standard and fall-through timing modes and status flags
`timescale 1ns/1ns
`default_nettype none
`include "fifo_flags_cfg.svh"

module dual_clock_fifo_flags (
  input wire logic clock,
  input wire logic rst,
  input wire logic write_clock,
  input wire logic write_enable_n,
  input wire logic [`FIFO_DATA_WIDTH-1:0] data_in,
  input wire logic read_clock,
  input wire logic read_enable_n,
  input wire logic master_reset_n,
  input wire logic timing_mode_strap_serial_in,
  input wire logic flag_timing_select,
  input wire logic [`FIFO_ADDR_WIDTH-1:0] empty_offset,
  input wire logic [`FIFO_ADDR_WIDTH-1:0] full_offset,
  output logic [`FIFO_DATA_WIDTH-1:0] data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_valid_n,
  output logic input_space_flag_n,
  output logic half_full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  output logic fall_through_mode
);

  fifo_flags_pkg::pin_sample_t pins_async;
  fifo_flags_pkg::pin_sample_t pins;
  fifo_flags_pkg::mode_cfg_t cfg;
  fifo_flags_pkg::ft_state_t ft_state;
  fifo_flags_pkg::ft_state_t next_ft_state;

  logic [`FIFO_DATA_WIDTH-1:0] mem [0:`FIFO_DEPTH-1];
  logic [`FIFO_ADDR_WIDTH-1:0] write_ptr;
  logic [`FIFO_ADDR_WIDTH-1:0] read_ptr;
  logic [`FIFO_COUNT_WIDTH-1:0] mem_count;
  logic [`FIFO_COUNT_WIDTH-1:0] next_mem_count;
  logic [`FIFO_COUNT_WIDTH-1:0] next_total;
  logic write_clock_prev;
  logic read_clock_prev;
  logic write_edge;
  logic read_edge;
  logic in_master_reset;
  logic clear;
  logic mem_full;
  logic mem_nonempty;
  logic do_write;
  logic std_read;
  logic ft_pop;
  logic pop;
  logic next_full;
  logic next_out_loaded;
  logic ir_stage;

  // Count compare shared by the level flags
  function automatic logic at_least(
    input logic [`FIFO_COUNT_WIDTH-1:0] count,
    input logic [`FIFO_COUNT_WIDTH-1:0] level
  );
    at_least = count >= level;
  endfunction

  assign pins_async.write_clock = write_clock;
  assign pins_async.write_enable_n = write_enable_n;
  assign pins_async.data_in = data_in;
  assign pins_async.read_clock = read_clock;
  assign pins_async.read_enable_n = read_enable_n;
  assign pins_async.master_reset_n = master_reset_n;
  assign pins_async.timing_mode_strap_serial_in = timing_mode_strap_serial_in;
  assign pins_async.flag_timing_select = flag_timing_select;
  assign pins_async.empty_offset = empty_offset;
  assign pins_async.full_offset = full_offset;

  pin_sync #(
    .WIDTH($bits(fifo_flags_pkg::pin_sample_t))
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pins_async),
    .sync_out(pins)
  );

  // Edge finding on the sampled port clocks
  always_ff @(posedge clock) begin
    if (rst) begin
      write_clock_prev <= 1'b0;
      read_clock_prev <= 1'b0;
    end else begin
      write_clock_prev <= pins.write_clock;
      read_clock_prev <= pins.read_clock;
    end
  end

  assign write_edge = pins.write_clock & ~write_clock_prev;
  assign read_edge = pins.read_clock & ~read_clock_prev;
  assign in_master_reset = ~pins.master_reset_n;
  assign clear = rst | in_master_reset;

  // Mode and offsets caught while master reset is held
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= '0;
    end else if (in_master_reset) begin
      cfg.fall_through_mode <= pins.timing_mode_strap_serial_in;
      cfg.sync_flag_timing <= pins.flag_timing_select;
      cfg.empty_offset <= pins.empty_offset;
      cfg.full_offset <= pins.full_offset;
    end
  end

  assign fall_through_mode = cfg.fall_through_mode;

  assign mem_full = mem_count == `FIFO_DEPTH_COUNT;
  assign mem_nonempty = mem_count != `FIFO_COUNT_ZERO;
  assign do_write = write_edge & ~pins.write_enable_n & ~mem_full & ~in_master_reset;
  assign std_read = ~cfg.fall_through_mode & read_edge & ~pins.read_enable_n
                    & mem_nonempty;

  // Fall-through presentation of the head word
  always_comb begin
    next_ft_state = ft_state;
    ft_pop = 1'b0;
    unique case (ft_state)
      fifo_flags_pkg::FT_EMPTY: begin
        if (read_edge && mem_nonempty) begin
          next_ft_state = fifo_flags_pkg::FT_EDGE_ONE;
        end
      end
      fifo_flags_pkg::FT_EDGE_ONE: begin
        if (read_edge) begin
          next_ft_state = fifo_flags_pkg::FT_EDGE_TWO;
        end
      end
      fifo_flags_pkg::FT_EDGE_TWO: begin
        if (read_edge) begin
          next_ft_state = fifo_flags_pkg::FT_LOADED;
          ft_pop = 1'b1;
        end
      end
      fifo_flags_pkg::FT_LOADED: begin
        if (read_edge && !pins.read_enable_n) begin
          if (mem_nonempty) begin
            ft_pop = 1'b1;
          end else begin
            next_ft_state = fifo_flags_pkg::FT_EMPTY;
          end
        end
      end
      default: begin
        next_ft_state = fifo_flags_pkg::FT_EMPTY;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (clear || !cfg.fall_through_mode) begin
      ft_state <= fifo_flags_pkg::FT_EMPTY;
    end else begin
      ft_state <= next_ft_state;
    end
  end

  assign pop = std_read | (cfg.fall_through_mode & ft_pop);
  assign next_out_loaded = cfg.fall_through_mode & (next_ft_state == fifo_flags_pkg::FT_LOADED);

  // Storage array
  always_ff @(posedge clock) begin
    if (do_write) begin
      mem[write_ptr] <= pins.data_in;
    end
  end

  always_ff @(posedge clock) begin
    if (clear) begin
      write_ptr <= '0;
    end else if (do_write) begin
      write_ptr <= write_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (clear) begin
      read_ptr <= '0;
    end else if (pop) begin
      read_ptr <= read_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (clear) begin
      data_out <= '0;
    end else if (pop) begin
      data_out <= mem[read_ptr];
    end
  end

  // Word count of the array, then of array plus output register
  always_comb begin
    next_mem_count = mem_count;
    if (do_write && !pop) begin
      next_mem_count = mem_count + `FIFO_COUNT_ONE;
    end else if (pop && !do_write) begin
      next_mem_count = mem_count - `FIFO_COUNT_ONE;
    end
  end

  assign next_total = next_mem_count + {{(`FIFO_COUNT_WIDTH-1){1'b0}}, next_out_loaded};
  assign next_full = cfg.fall_through_mode ? (next_total == `FIFO_DEPTH_COUNT + `FIFO_COUNT_ONE)
                                           : (next_mem_count == `FIFO_DEPTH_COUNT);

  always_ff @(posedge clock) begin
    if (clear) begin
      mem_count <= `FIFO_COUNT_ZERO;
    end else begin
      mem_count <= next_mem_count;
    end
  end

  // Standard-mode empty flag on read edges
  always_ff @(posedge clock) begin
    if (clear || cfg.fall_through_mode) begin
      empty_flag_n <= cfg.fall_through_mode & ~in_master_reset & ~rst;
    end else if (read_edge) begin
      empty_flag_n <= next_mem_count != `FIFO_COUNT_ZERO;
    end
  end

  // Standard-mode full flag on write edges
  always_ff @(posedge clock) begin
    if (clear || cfg.fall_through_mode) begin
      full_flag_n <= 1'b1;
    end else if (write_edge) begin
      full_flag_n <= ~next_full;
    end
  end

  // Output-valid follows the head-word register
  always_ff @(posedge clock) begin
    if (clear || !cfg.fall_through_mode) begin
      output_valid_n <= 1'b1;
    end else begin
      output_valid_n <= ~next_out_loaded;
    end
  end

  // Input-space: full shows at once, release passes two write-edge stages
  always_ff @(posedge clock) begin
    if (clear || !cfg.fall_through_mode) begin
      ir_stage <= 1'b0;
      input_space_flag_n <= cfg.fall_through_mode ? 1'b0 : 1'b1;
    end else if (next_full) begin
      ir_stage <= 1'b1;
      input_space_flag_n <= 1'b1;
    end else if (write_edge) begin
      ir_stage <= 1'b0;
      input_space_flag_n <= ir_stage;
    end
  end

  // Half-full
  always_ff @(posedge clock) begin
    if (clear) begin
      half_full_flag_n <= 1'b1;
    end else if (cfg.fall_through_mode) begin
      half_full_flag_n <= ~at_least(next_total, `FIFO_HALF_FT);
    end else begin
      half_full_flag_n <= ~at_least(next_mem_count, `FIFO_HALF_STD);
    end
  end

  // Almost-empty, on read edges only under synchronous flag timing
  always_ff @(posedge clock) begin
    if (clear) begin
      almost_empty_flag_n <= 1'b0;
    end else if (!cfg.sync_flag_timing || read_edge) begin
      if (cfg.fall_through_mode) begin
        almost_empty_flag_n <= at_least(next_total,
          {1'b0, cfg.empty_offset} + `FIFO_AE_FT_EXTRA);
      end else begin
        almost_empty_flag_n <= at_least(next_mem_count,
          {1'b0, cfg.empty_offset} + `FIFO_AE_STD_EXTRA);
      end
    end
  end

  // Almost-full, on write edges only under synchronous flag timing
  always_ff @(posedge clock) begin
    if (clear) begin
      almost_full_flag_n <= 1'b1;
    end else if (!cfg.sync_flag_timing || write_edge) begin
      if (cfg.fall_through_mode) begin
        almost_full_flag_n <= ~at_least(next_total,
          `FIFO_DEPTH_COUNT + `FIFO_COUNT_ONE - {1'b0, cfg.full_offset});
      end else begin
        almost_full_flag_n <= ~at_least(next_mem_count,
          `FIFO_DEPTH_COUNT - {1'b0, cfg.full_offset});
      end
    end
  end

endmodule

`default_nettype wire

// >>> fifo_flags_cfg.svh
// Constants of the dual-clock FIFO flag and read-timing logic
`ifndef FIFO_FLAGS_CFG_SVH
`define FIFO_FLAGS_CFG_SVH

`define FIFO_DATA_WIDTH 36
`define FIFO_DEPTH 1024
`define FIFO_ADDR_WIDTH 10
`define FIFO_COUNT_WIDTH 11
`define FIFO_DEPTH_COUNT 11'h400
`define FIFO_HALF_STD 11'h201
`define FIFO_HALF_FT 11'h202
`define FIFO_AE_STD_EXTRA 11'h001
`define FIFO_AE_FT_EXTRA 11'h002
`define FIFO_COUNT_ZERO 11'h000
`define FIFO_COUNT_ONE 11'h001

`endif

// >>> fifo_flags_pkg.sv
// Types of the dual-clock FIFO flag and read-timing logic
package fifo_flags_pkg;

  typedef struct packed {
    logic write_clock;
    logic write_enable_n;
    logic [35:0] data_in;
    logic read_clock;
    logic read_enable_n;
    logic master_reset_n;
    logic timing_mode_strap_serial_in;
    logic flag_timing_select;
    logic [9:0] empty_offset;
    logic [9:0] full_offset;
  } pin_sample_t;

  typedef enum logic [3:0] {
    FT_EMPTY = 4'b0001,
    FT_EDGE_ONE = 4'b0010,
    FT_EDGE_TWO = 4'b0100,
    FT_LOADED = 4'b1000
  } ft_state_t;

  typedef struct packed {
    logic fall_through_mode;
    logic sync_flag_timing;
    logic [9:0] empty_offset;
    logic [9:0] full_offset;
  } mode_cfg_t;

endpackage

// >>> pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// >>> dual_clock_fifo_flags_sva.sv
// Checker for the FIFO flag outputs
`timescale 1ns/1ns
`default_nettype none
module dual_clock_fifo_flags_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic master_reset_n,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic flag_timing_select,
  input wire logic [9:0] empty_offset,
  input wire logic [35:0] data_out,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic output_valid_n,
  input wire logic input_space_flag_n,
  input wire logic half_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic fall_through_mode
);
  logic [3:0] settle;
  logic ready;
  logic sync_sel;
  // Copy of the flag timing strap as caught during master reset
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_sel <= 1'b0;
    end else if (!master_reset_n) begin
      sync_sel <= flag_timing_select;
    end
  end
  // Counts cycles since master reset ended, so sync delays have passed
  always_ff @(posedge clock) begin
    if (rst || !master_reset_n) begin
      settle <= 4'h0;
    end else if (settle != 4'hf) begin
      settle <= settle + 4'h1;
    end
  end
  assign ready = settle > 4'h6;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_mode_held: assert property (ready |-> $stable(fall_through_mode))
    else $error("timing mode changed outside master reset");
  a_std_pins_idle: assert property (ready && !fall_through_mode |-> output_valid_n && input_space_flag_n)
    else $error("fall-through flags active in standard mode");
  a_ft_pins_idle: assert property (ready && fall_through_mode |-> empty_flag_n && full_flag_n)
    else $error("standard flags active in fall-through mode");
  a_empty_full_excl: assert property (ready |-> empty_flag_n || full_flag_n)
    else $error("empty and full at once");
  a_half_not_ae: assert property (ready && !half_full_flag_n && empty_offset < 10'h1ff |-> almost_empty_flag_n)
    else $error("almost empty while above half");
  a_data_with_valid: assert property (ready && fall_through_mode && data_out != $past(data_out) |-> ##[0:2] !output_valid_n)
    else $error("data changed without a valid word");
  a_full_has_head: assert property (ready && fall_through_mode && input_space_flag_n |-> !output_valid_n && !almost_full_flag_n)
    else $error("full without head word or almost full");
  a_full_std_flags: assert property (ready && !full_flag_n |-> !almost_full_flag_n && !half_full_flag_n)
    else $error("full without almost full and half full");
  a_empty_ae_low: assert property (ready && empty_offset > 10'h003 && (fall_through_mode ? output_valid_n : !empty_flag_n) |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  a_ae_sync_edge: assert property (sync_sel && ready && $changed(almost_empty_flag_n) |-> read_clock)
    else $error("almost empty moved away from a read clock rise");
  a_af_sync_edge: assert property (sync_sel && ready && $changed(almost_full_flag_n) |-> write_clock)
    else $error("almost full moved away from a write clock rise");
  c_ov_fell: cover property ($fell(output_valid_n));
  c_ir_rose: cover property ($rose(input_space_flag_n));
  c_ff_fell: cover property ($fell(full_flag_n));
endmodule
bind dual_clock_fifo_flags dual_clock_fifo_flags_sva u_dual_clock_fifo_flags_sva (
  .clock(clock), .rst(rst), .master_reset_n(master_reset_n), .write_clock(write_clock),
  .read_clock(read_clock), .flag_timing_select(flag_timing_select), .empty_offset(empty_offset),
  .data_out(data_out), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
  .output_valid_n(output_valid_n), .input_space_flag_n(input_space_flag_n),
  .half_full_flag_n(half_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
  .almost_full_flag_n(almost_full_flag_n), .fall_through_mode(fall_through_mode));
`default_nettype wire

// >>> fifo_port_model.sv
// Writer and reader logic on free-running port clocks
`timescale 1ns/1ns
`default_nettype none
module fifo_port_model (
  output logic write_clock,
  output logic write_enable_n,
  output logic [35:0] data_in,
  output logic read_clock,
  output logic read_enable_n
);
  initial begin
    write_enable_n = 1'b1;
    read_enable_n = 1'b1;
    data_in = 36'h0;
  end
  initial begin
    write_clock = 1'b0;
    #3;
    forever #16 write_clock = ~write_clock;
  end
  initial begin
    read_clock = 1'b0;
    #7;
    forever #16 read_clock = ~read_clock;
  end
  // Enable held low across each rising edge; released data lines invert
  task automatic write_words(input logic [35:0] first, input int count);
    for (int i = 0; i < count; i++) begin
      @(negedge write_clock);
      write_enable_n <= 1'b0;
      data_in <= first + 36'(i);
    end
    @(negedge write_clock);
    write_enable_n <= 1'b1;
    data_in <= ~data_in;
  endtask
  // Requests count words, one per read clock rise
  task automatic read_words(input int count);
    @(negedge read_clock);
    read_enable_n <= 1'b0;
    repeat (count) @(negedge read_clock);
    read_enable_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> tb_dual_clock_fifo_flags.sv
// Self-checking bench of the dual-clock FIFO flags
`timescale 1ns/1ns
`default_nettype none
module tb_dual_clock_fifo_flags;
  typedef struct packed {
    logic strap;
    logic [10:0] words;
    logic [6:0] flags;
  } row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic master_reset_n = 1'b0;
  logic strap = 1'b0;
  logic flag_timing_select = 1'b0;
  logic [9:0] empty_offset = 10'h004;
  logic [9:0] full_offset = 10'h008;
  logic write_clock, write_enable_n, read_clock, read_enable_n, fall_through_mode;
  logic empty_flag_n, full_flag_n, output_valid_n, input_space_flag_n;
  logic half_full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic [35:0] data_in, data_out;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_t rows [10];
  fifo_port_model u_fifo_port_model (.write_clock(write_clock),
    .write_enable_n(write_enable_n), .data_in(data_in), .read_clock(read_clock),
    .read_enable_n(read_enable_n));
  dual_clock_fifo_flags u_dual_clock_fifo_flags (.clock(clock), .rst(rst),
    .write_clock(write_clock), .write_enable_n(write_enable_n), .data_in(data_in),
    .read_clock(read_clock), .read_enable_n(read_enable_n), .master_reset_n(master_reset_n),
    .timing_mode_strap_serial_in(strap), .flag_timing_select(flag_timing_select),
    .empty_offset(empty_offset), .full_offset(full_offset), .data_out(data_out),
    .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n), .output_valid_n(output_valid_n),
    .input_space_flag_n(input_space_flag_n), .half_full_flag_n(half_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .fall_through_mode(fall_through_mode));
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check_flags(input logic [6:0] expected);
    logic [6:0] seen;
    seen = {empty_flag_n, full_flag_n, output_valid_n, input_space_flag_n,
      half_full_flag_n, almost_empty_flag_n, almost_full_flag_n};
    samples_checked++;
    if (seen !== expected) begin
      fail_count++;
      $display("unexpected flags at %0t: got %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic check_word(input logic [35:0] seen, input logic [35:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      fail_count++;
      $display("unexpected word at %0t: got %h expected %h", $time, seen, expected);
    end
  endtask
  task automatic master_reset(input logic mode);
    @(posedge clock);
    master_reset_n <= 1'b0;
    strap <= mode;
    repeat (8) @(posedge clock);
    master_reset_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  task automatic settle();
    repeat (96) @(posedge clock);
  endtask
  initial begin
    // Flags: empty, full, valid, input space, half, almost empty, almost full
    rows = '{'{1'b0, 11'h000, 7'h3d}, '{1'b0, 11'h005, 7'h7f}, '{1'b0, 11'h201, 7'h7b},
      '{1'b0, 11'h3f8, 7'h7a}, '{1'b0, 11'h400, 7'h5a}, '{1'b1, 11'h000, 7'h75},
      '{1'b1, 11'h006, 7'h67}, '{1'b1, 11'h202, 7'h63}, '{1'b1, 11'h3f9, 7'h62},
      '{1'b1, 11'h401, 7'h6a}};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      master_reset(rows[i].strap);
      u_fifo_port_model.write_words(36'h1000, int'(rows[i].words));
      settle();
      check_flags(rows[i].flags);
      $display("row %0d done", i);
    end
    u_fifo_port_model.read_words(1);
    settle();
    check_flags(7'h62);
    check_word(data_out, 36'h1001);
    $display("read from full done");
    master_reset(1'b0);
    u_fifo_port_model.write_words(36'h0b0, 2);
    u_fifo_port_model.read_words(1);
    settle();
    check_word(data_out, 36'h0b0);
    u_fifo_port_model.read_words(3);
    settle();
    check_word(data_out, 36'h0b1);
    check_flags(7'h3d);
    $display("standard read done");
    master_reset(1'b1);
    strap <= 1'b0;
    u_fifo_port_model.write_words(36'h0a0, 3);
    settle();
    check_word({35'h0, fall_through_mode}, 36'h1);
    check_word(data_out, 36'h0a0);
    u_fifo_port_model.read_words(2);
    settle();
    check_word(data_out, 36'h0a2);
    u_fifo_port_model.read_words(2);
    settle();
    check_flags(7'h75);
    $display("fall-through read done");
    // Synchronous almost flags with other offsets, fall-through mode
    flag_timing_select <= 1'b1;
    empty_offset <= 10'h005;
    full_offset <= 10'h3f0;
    master_reset(1'b1);
    u_fifo_port_model.write_words(36'h0c00, 17);
    settle();
    check_flags(7'h66);
    u_fifo_port_model.read_words(12);
    settle();
    check_flags(7'h65);
    check_word(data_out, 36'h0c0c);
    $display("synchronous flag timing done");
    results();
  end
endmodule
`default_nettype wire
